/* logic/i2c_config_slave.v */
// Two-wire configuration slave with its write FIFO and byte store
`timescale 1ns/1ps
`include "i2c_config_slave_map.vh"

// ----------------------------------------
// Write record FIFO
// ----------------------------------------
module cfg_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire mclk,
  input wire sys_rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] slots [0:DEPTH-1]; // Storage, flip-flops
  reg [AW:0] wr_ptr; // Write pointer, extra wrap bit
  reg [AW:0] rd_ptr; // Read pointer, extra wrap bit
  wire full; // All slots taken
  wire empty; // Nothing stored
  assign full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty = (wr_ptr == rd_ptr);
  assign in_ready = ~full;
  assign out_valid = ~empty;
  assign out_data = slots[rd_ptr[AW-1:0]];
  // Pointer update; push and pop may share a cycle
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end
    else
    begin
      if (in_valid && !full)
      begin
        // Store and advance
        slots[wr_ptr[AW-1:0]] <= in_data;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_ready && !empty)
      begin
        // Drained by the consumer
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule // cfg_fifo

// ----------------------------------------
// Slave top
// ----------------------------------------
module i2c_config_slave #(
  parameter DEPTH = 256,
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW = 5
) (
  input wire mclk,
  input wire sys_rst,
  input wire scl_in,
  output wire scl_out,
  output wire scl_oe,
  input wire sda_in,
  output wire sda_out,
  output reg sda_oe,
  input wire [3:0] strap_addr,
  input wire small_pkg,
  output wire wr_valid,
  input wire wr_ready,
  output wire [7:0] wr_addr,
  output wire [7:0] wr_data,
  output reg selected
);
  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_IDLE = 3'b000;
  localparam ST_ADDR = 3'b001;
  localparam ST_ACK_ADDR = 3'b010;
  localparam ST_WRITE = 3'b011;
  localparam ST_ACK_WR = 3'b100;
  localparam ST_READ = 3'b101;
  localparam ST_ACK_RD = 3'b110;
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg [2:0] scl_sync; // Clock line synchroniser chain
  reg [2:0] sda_sync; // Data line synchroniser chain
  reg scl_f; // Filtered clock level
  reg sda_f; // Filtered data level
  reg scl_d; // Previous filtered clock
  reg sda_d; // Previous filtered data
  wire scl_rise; // Clock rising edge
  wire scl_fall; // Clock falling edge
  wire start_cond; // Start seen
  wire stop_cond; // Stop seen
  reg [2:0] state; // Protocol state
  reg [3:0] bit_cnt; // Bits taken in this byte
  reg [7:0] rx_byte; // Receive shifter
  reg [7:0] tx_byte; // Transmit shifter
  reg [7:0] ptr; // Byte pointer
  reg rw_read; // Direction latched from address byte
  reg [7:0] store [0:DEPTH-1]; // Configuration bytes
  wire [6:0] own_addr; // Our slave address
  wire [7:0] base_ptr; // First location for this strap
  wire fifo_in_ready; // Room for one more write
  reg fifo_push; // One-cycle push strobe
  reg [15:0] fifo_in; // Pointer and data record
  wire [15:0] fifo_out; // Record at FIFO head
  wire drain; // Record leaves FIFO this cycle
  integer i; // Store reset index
  // ----------------------------------------
  // Address and base location
  // ----------------------------------------
  // Upper bits fixed, lower from straps; small package pins bit zero high
  assign own_addr = {`ADDR_FIXED_HI, strap_addr[3:1], strap_addr[0] | small_pkg}; // R3 R16
  // Base location is the strap nibble in the upper half of the pointer
  assign base_ptr = {strap_addr, `STRAP_SHIFT}; // R15
  // Clock line is never pulled, so no stretching ever happens
  assign scl_out = 1'b0; // R7
  assign scl_oe = 1'b0; // R7
  // Open drain: only ever drives low
  assign sda_out = 1'b0;
  // ----------------------------------------
  // Line synchronisers and filter
  // ----------------------------------------
  // Three stages; a level counts once the last two agree
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      scl_sync <= {3{`LINE_IDLE}};
      sda_sync <= {3{`LINE_IDLE}};
      scl_f <= `LINE_IDLE;
      sda_f <= `LINE_IDLE;
      scl_d <= `LINE_IDLE;
      sda_d <= `LINE_IDLE;
    end
    else
    begin
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_sync <= {sda_sync[1:0], sda_in};
      // Agreement of stages two and three filters one-cycle glitches
      if (scl_sync[1] == scl_sync[2])
        scl_f <= scl_sync[2];
      if (sda_sync[1] == sda_sync[2])
        sda_f <= sda_sync[2];
      scl_d <= scl_f;
      sda_d <= sda_f;
    end
  end
  // Edge and condition detection on filtered levels
  assign scl_rise = scl_f & ~scl_d;
  assign scl_fall = ~scl_f & scl_d;
  // Data falling while clock stays high
  assign start_cond = scl_f & scl_d & sda_d & ~sda_f; // R13
  // Data rising while clock stays high
  assign stop_cond = scl_f & scl_d & ~sda_d & sda_f; // R14
  // ----------------------------------------
  // Protocol engine
  // ----------------------------------------
  // Samples on clock rise, changes the data line on clock fall
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      state <= ST_IDLE;
      bit_cnt <= `BIT_CNT_ZERO;
      rx_byte <= `BYTE_RESET;
      tx_byte <= `BYTE_RESET;
      ptr <= `PTR_RESET;
      rw_read <= 1'b0;
      sda_oe <= 1'b0;
      selected <= 1'b0;
      fifo_push <= 1'b0;
      fifo_in <= {`PTR_RESET, `BYTE_RESET};
    end
    else
    begin
      fifo_push <= 1'b0;
      if (start_cond)
      begin
        // A transfer always opens here; repeated start too
        state <= ST_ADDR; // R10 R11
        bit_cnt <= `BIT_CNT_ZERO;
        ptr <= base_ptr; // R18
        sda_oe <= 1'b0;
        selected <= 1'b0;
      end
      else if (stop_cond)
      begin
        // Stop ends any transfer; writes end here
        state <= ST_IDLE; // R4
        sda_oe <= 1'b0;
        selected <= 1'b0;
      end
      else
      begin
        case (state)
          ST_IDLE:
            // Released bus, waiting for start
            sda_oe <= 1'b0; // R17
          ST_ADDR:
          begin
            if (scl_rise)
            begin
              // Address and direction, first bit is most significant
              rx_byte <= {rx_byte[6:0], sda_f}; // R6
              bit_cnt <= bit_cnt + 1'b1;
            end
            else if (scl_fall && bit_cnt == `BITS_PER_BYTE)
            begin
              if (rx_byte[7:1] == own_addr)
              begin
                // Match: acknowledge and remember direction
                state <= ST_ACK_ADDR; // R11 R1
                sda_oe <= 1'b1; // R8
                rw_read <= rx_byte[0];
                selected <= 1'b1;
              end
              else
              begin
                // Not ours: stay off the bus until next start
                state <= ST_IDLE; // R17
                sda_oe <= 1'b0;
              end
            end
          end
          ST_ACK_ADDR:
          begin
            if (scl_fall)
            begin
              bit_cnt <= `BIT_CNT_ZERO;
              if (rw_read)
              begin
                // Present first read byte, top bit first
                state <= ST_READ;
                tx_byte <= store[ptr];
                sda_oe <= ~store[ptr][7]; // R6
              end
              else
              begin
                state <= ST_WRITE;
                sda_oe <= 1'b0;
              end
            end
          end
          ST_WRITE:
          begin
            if (scl_rise)
            begin
              rx_byte <= {rx_byte[6:0], sda_f}; // R6
              bit_cnt <= bit_cnt + 1'b1;
            end
            else if (scl_fall && bit_cnt == `BITS_PER_BYTE)
            begin
              // Full byte in: ninth slot is the acknowledge
              state <= ST_ACK_WR; // R5
              if (fifo_in_ready)
              begin
                // Queue byte at current location, then step up
                fifo_push <= 1'b1; // R4
                fifo_in <= {ptr, rx_byte};
                ptr <= ptr + 1'b1; // R2 R18
                sda_oe <= 1'b1; // R8
              end
              else
                // FIFO full: refuse the byte with a nack, pointer holds
                sda_oe <= 1'b0;
            end
          end
          ST_ACK_WR:
          begin
            if (scl_fall)
            begin
              // Release after the acknowledge pulse
              state <= ST_WRITE;
              bit_cnt <= `BIT_CNT_ZERO;
              sda_oe <= 1'b0;
            end
          end
          ST_READ:
          begin
            if (scl_rise)
              bit_cnt <= bit_cnt + 1'b1;
            else if (scl_fall)
            begin
              if (bit_cnt == `BITS_PER_BYTE)
              begin
                // Byte sent: free the line for the master's answer
                state <= ST_ACK_RD; // R5 R9
                sda_oe <= 1'b0;
                ptr <= ptr + 1'b1; // R2 R18
              end
              else
              begin
                // Next bit down
                tx_byte <= {tx_byte[6:0], 1'b0}; // R6
                sda_oe <= ~tx_byte[6];
              end
            end
          end
          ST_ACK_RD:
          begin
            if (scl_rise)
            begin
              // Nack ends the read; stop follows
              if (sda_f)
                state <= ST_IDLE; // R12
            end
            else if (scl_fall)
            begin
              // Master acknowledged: send next location
              state <= ST_READ; // R9
              bit_cnt <= `BIT_CNT_ZERO;
              tx_byte <= store[ptr];
              sda_oe <= ~store[ptr][7];
            end
          end
          default:
          begin
            state <= ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Write path
  // ----------------------------------------
  // Decouples the slow link from the consumer; a stalled consumer
  // fills the FIFO and the slave then nacks further bytes
  cfg_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data(fifo_in),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data(fifo_out)
  );
  assign wr_addr = fifo_out[15:8];
  assign wr_data = fifo_out[7:0];
  assign drain = wr_valid & wr_ready;
  // Store updates only when the consumer takes the record, so reads
  // may see old values while writes still sit in the FIFO
  always @(posedge mclk)
  begin
    if (sys_rst)
    begin
      for (i = 0; i < DEPTH; i = i + 1)
        store[i] <= `BYTE_RESET;
    end
    else if (drain)
      store[wr_addr] <= wr_data;
  end
endmodule // i2c_config_slave

/* logic/i2c_config_slave_map.vh */
// Constants for the two-wire configuration slave
// Operation
// R1 - Slave only, standard mode, 7-bit address, bytes
// R2 - Bytes accessed in ascending order, stop anywhere
// R3 - Low four address bits from strap inputs
// R4 - Write bytes accepted until stop condition; code nacks them while the write FIFO is full
// R5 - Eight bits per byte, then acknowledge slot
// R6 - Most significant bit shifted first
// R7 - Clock line is never driven
// R8 - Data held low through acknowledge high
// R9 - Master acknowledges bytes it reads
// R10 - Master opens each transfer with start
// R11 - Address match after start selects read/write
// R12 - Master ends read with nack, stop
// R13 - Start: data falls while clock high
// R14 - Stop: data rises while clock high
// R15 - Start location is strap value times sixteen
// R16 - Small package forces address bit zero high
// R17 - Mismatch releases data, waits next start
// R18 - Pointer reloads at start, steps per byte
`ifndef I2C_CONFIG_SLAVE_MAP_VH
`define I2C_CONFIG_SLAVE_MAP_VH

// ----------------------------------------
// Address and bit framing
// ----------------------------------------
`define ADDR_FIXED_HI 3'b111
`define BITS_PER_BYTE 4'h8
`define BIT_CNT_ZERO 4'h0
`define STRAP_SHIFT 4'h0
`define LINK_RATE_KBPS 100

// ----------------------------------------
// Reset values
// ----------------------------------------
`define PTR_RESET 8'h00
`define BYTE_RESET 8'h00
`define LINE_IDLE 1'b1

`endif

/* tb/i2c_config_slave_assertions.sv */
// Port checks for the configuration slave
`timescale 1ns/1ps
// ---
// Checker
// ---
module i2c_config_slave_chk (
  input wire mclk,
  input wire sys_rst,
  input wire scl_in,
  input wire scl_oe,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe,
  input wire wr_valid,
  input wire wr_ready,
  input wire [7:0] wr_addr,
  input wire [7:0] wr_data,
  input wire selected
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Bus conditions on the raw pins
  sequence start_seen;
    scl_in && $past(scl_in) && $fell(sda_in);
  endsequence
  sequence stop_seen;
    scl_in && $past(scl_in) && $rose(sda_in);
  endsequence
  a_clock_never_driven: assert property (!scl_oe)
    else $error("clock driven");
  a_oe_pulls_low: assert property (sda_oe |-> !sda_out)
    else $error("data driven high");
  a_ack_stable_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("data drive moved while clock high");
  a_drive_in_low: assert property ($rose(sda_oe) |-> !scl_in [*2])
    else $error("drive began late");
  a_start_deselect: assert property (start_seen |-> ##[1:10] !selected)
    else $error("start not seen");
  a_stop_deselect: assert property (stop_seen |-> ##[1:10] !selected)
    else $error("stop not seen");
  a_record_held: assert property (wr_valid && !wr_ready |=>
    wr_valid && $stable(wr_addr) && $stable(wr_data))
    else $error("record lost");
  a_record_selected: assert property ($rose(wr_valid) |-> $past(selected, 3))
    else $error("record while unselected");
endmodule // i2c_config_slave_chk

bind i2c_config_slave i2c_config_slave_chk u_chk (.mclk, .sys_rst, .scl_in, .scl_oe,
  .sda_in, .sda_out, .sda_oe, .wr_valid, .wr_ready, .wr_addr, .wr_data, .selected);

/* tb/i2c_config_slave_tb.sv */
// Testbench for the configuration slave
`timescale 1ns/1ps
module i2c_config_slave_tb;
  reg mclk = 1'b0;
  reg sys_rst = 1'b1;
  reg [3:0] strap_addr = 4'h5;
  reg small_pkg = 1'b0;
  reg wr_ready = 1'b0;
  integer failures = 0;
  integer cmp_count = 0;
  integer i;
  reg ack;
  reg [7:0] d;
  wire scl_m, sda_m, scl_oe, scl_out, sda_oe, sda_out, wr_valid, selected;
  wire [7:0] wr_addr, wr_data;
  // Open-drain wires with pull-ups
  wire scl_w = scl_m & ~(scl_oe & ~scl_out);
  wire sda_w = sda_m & ~(sda_oe & ~sda_out);
  // Free-running 100 MHz system clock
  always #5 mclk = ~mclk;
  i2c_master_model m (.mclk, .sda_line(sda_w), .scl_m, .sda_m);
  i2c_config_slave dut (.mclk, .sys_rst, .scl_in(scl_w), .scl_out, .scl_oe, .sda_in(sda_w),
    .sda_out, .sda_oe, .strap_addr, .small_pkg, .wr_valid, .wr_ready, .wr_addr, .wr_data,
    .selected);
  // ---
  // Compare and drain helpers
  // ---
  task chk_bit(input reg g, input reg e);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e)
      begin
        failures = failures + 1;
        $display("MISMATCH %0t bit %b exp %b", $time, g, e);
      end
    end
  endtask
  task chk_byte(input reg [7:0] g, input reg [7:0] e);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e)
      begin
        failures = failures + 1;
        $display("MISMATCH %0t byte %h exp %h", $time, g, e);
      end
    end
  endtask
  // Bounded wait for a record, then one-cycle accept
  task pop(input reg [7:0] ea, input reg [7:0] ed);
    integer n;
    begin
      // Let an edge pass so the strobe never changes twice in one step
      @(negedge mclk);
      n = 0;
      while (wr_valid !== 1'b1 && n < 50)
      begin
        @(negedge mclk);
        n = n + 1;
      end
      chk_bit(wr_valid, 1'b1);
      chk_byte(wr_addr, ea);
      chk_byte(wr_data, ed);
      wr_ready = 1'b1;
      @(negedge mclk);
      wr_ready = 1'b0;
    end
  endtask
  // ---
  // Scenarios
  // ---
  task t_write;
    begin
      m.start;
      m.send_byte({3'b111, strap_addr, 1'b0}, ack);
      chk_bit(ack, 1'b1);
      chk_bit(selected, 1'b1);
      chk_bit(scl_out | scl_oe, 1'b0);
      m.send_byte(8'h81, ack);
      chk_bit(ack, 1'b1);
      m.send_byte(8'h3c, ack);
      chk_bit(ack, 1'b1);
      m.start;
      m.send_byte({3'b111, strap_addr, 1'b0}, ack);
      m.send_byte(8'h5a, ack);
      m.stop;
      chk_bit(selected, 1'b0);
      pop(8'h50, 8'h81);
      pop(8'h51, 8'h3c);
      pop(8'h50, 8'h5a);
    end
  endtask
  task t_read;
    begin
      m.start;
      m.send_byte({3'b111, strap_addr, 1'b1}, ack);
      m.recv_byte(1'b1, d);
      chk_byte(d, 8'h5a);
      m.recv_byte(1'b0, d);
      chk_byte(d, 8'h3c);
      m.stop;
    end
  endtask
  // Foreign address, then an all-zero byte that must stay unanswered
  task t_mismatch;
    begin
      m.start;
      m.send_byte({3'b111, 4'h3, 1'b0}, ack);
      chk_bit(ack, 1'b0);
      m.send_byte(8'h00, ack);
      chk_bit(ack, 1'b0);
      chk_bit(selected, 1'b0);
      m.stop;
      chk_bit(wr_valid, 1'b0);
    end
  endtask
  task t_small;
    begin
      small_pkg = 1'b1;
      strap_addr = 4'h2;
      m.start;
      m.send_byte({3'b111, 4'h2, 1'b0}, ack);
      chk_bit(ack, 1'b0);
      m.start;
      m.send_byte({3'b111, 4'h3, 1'b0}, ack);
      chk_bit(ack, 1'b1);
      m.send_byte(8'h77, ack);
      m.stop;
      pop(8'h20, 8'h77);
      small_pkg = 1'b0;
    end
  endtask
  // Fill the buffer with the consumer stalled until a byte is refused
  task t_full;
    begin
      strap_addr = 4'h0;
      m.start;
      m.send_byte(8'he0, ack);
      for (i = 0; i < 33; i = i + 1)
      begin
        m.send_byte(i[7:0], ack);
        chk_bit(ack, i < 32);
      end
      m.stop;
      for (i = 0; i < 32; i = i + 1)
        pop(i[7:0], i[7:0]);
      chk_bit(wr_valid, 1'b0);
    end
  endtask
  task print_verdict;
    begin
      $display("failures=%0d cmp_count=%0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // Hold reset for 12 cycles, then run each scenario in turn
  initial
  begin
    repeat (12) @(negedge mclk);
    sys_rst = 1'b0;
    repeat (8) @(negedge mclk);
    t_write;
    t_read;
    t_mismatch;
    t_small;
    t_full;
    print_verdict;
  end
  // Watchdog well beyond the expected run
  initial
  begin
    // Scenarios need about 7000 cycles; limit is over five times that
    #400000;
    failures = failures + 1;
    $display("MISMATCH %0t watchdog expired", $time);
    print_verdict;
  end
endmodule // i2c_config_slave_tb

/* tb/i2c_master_model.sv */
// Behavioural bus master driving the slave's clock and data pins
`timescale 1ns/1ps
// ---
// Master model
// ---
module i2c_master_model (
  input wire mclk,
  input wire sda_line,
  output reg scl_m,
  output reg sda_m
);
  integer i;
  reg r;
  // Both lines released at idle, pull-ups hold them high
  initial
  begin
    scl_m = 1'b1;
    sda_m = 1'b1;
  end
  // One quarter of a 160 ns bit, paced on falling mclk
  task step(input reg s, input reg d);
    begin
      scl_m = s;
      sda_m = d;
      repeat (4) @(negedge mclk);
    end
  endtask
  // Data falls while clock high; also serves as repeated start
  task start;
    begin
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
    end
  endtask
  // Data rises while clock high
  task stop;
    begin
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
      step(1'b1, 1'b1);
    end
  endtask
  // Data set mid-low, sampled mid-high
  task xbit(input reg b, output reg s);
    begin
      step(1'b0, b);
      step(1'b1, b);
      s = sda_line;
      step(1'b1, b);
      step(1'b0, b);
    end
  endtask
  task send_byte(input reg [7:0] d, output reg ack);
    begin
      for (i = 7; i >= 0; i = i - 1)
        xbit(d[i], r);
      xbit(1'b1, r);
      ack = ~r;
    end
  endtask
  // Last byte of a read gets no acknowledge
  task recv_byte(input reg more, output reg [7:0] d);
    begin
      for (i = 7; i >= 0; i = i - 1)
        xbit(1'b1, d[i]);
      xbit(~more, r);
    end
  endtask
endmodule // i2c_master_model
